//--- verilog/fml_map.svh
// Register offsets, field positions, reset values for the fault block
`ifndef FML_MAP_SVH
`define FML_MAP_SVH

// ==========================================================
// Register offsets (15-bit serial port address)
`define FML_ADDR_SUMMARY    15'h02c0
`define FML_ADDR_STATUS     15'h02c1
`define FML_ADDR_MASK       15'h02c2
`define FML_ADDR_LANES_LO   15'h02c4
`define FML_ADDR_LANES_HI   15'h02c5

// ==========================================================
// Field positions and reset values
`define FML_BIT_LANE_BUF    5
`define FML_FLAG_MSB        5
`define FML_MASK_RST        8'h3f
`define FML_STATUS_RST      8'h3f
`define FML_LANES_RST       16'hffff

// ==========================================================
// Serial frame layout
`define FML_FRAME_BITS      5'd24
`define FML_LAST_BIT        5'd23
`define FML_ADDR_LAST_BIT   5'd15
`define FML_DATA_FIRST      5'd16

`endif

//--- verilog/fml_pkg.sv
// Types shared by the fault block and its serial register port
package fml_pkg;

  // ==========================================================
  // Fault condition inputs other than the lane buffers
  typedef struct packed {
    logic lock_loss;
    logic link_state;
    logic realign;
    logic osc_phase;
    logic divider;
  } fml_fault_src_t;

  // Register request from the serial port
  typedef struct packed {
    logic        wr;
    logic [14:0] addr;
    logic [7:0]  data;
  } fml_reg_req_t;

  // Serial port state
  typedef struct packed {
    logic        sclk_q;
    logic [4:0]  cnt;
    logic [23:0] sh;
    logic [7:0]  tx;
    logic        rd;
    logic        load;
    logic        sdo;
    logic        sdo_oe;
    fml_reg_req_t req;
  } fml_spi_t;

  // Fault register state
  typedef struct packed {
    logic [7:0]  mask;
    logic [7:0]  status;
    logic [15:0] lanes;
    logic        summary;
    logic        cal_pin;
  } fml_core_t;

endpackage : fml_pkg

//--- verilog/fml_spi_slave.sv
// Serial register port: 24-bit frames, mode 0, sampled on clk
`timescale 1ns/1ns
`include "fml_map.svh"
module fml_spi_slave
  import fml_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Serial pins
  input  wire logic         sclk,
  input  wire logic         cs_n,
  input  wire logic         sdi,
  output logic              sdo,
  output logic              sdo_oe,
  // Register side
  output fml_reg_req_t      req,
  input  wire logic [7:0]   rd_data
);

  fml_spi_t st;
  fml_spi_t next_st;
  logic [23:0] shifted;
  logic        rise;
  logic        fall;

  assign rise    = sclk & ~st.sclk_q;
  assign fall    = ~sclk & st.sclk_q;
  assign shifted = {st.sh[22:0], sdi};

  // ==========================================================
  // Frame engine
  always_comb begin
    next_st        = st;
    next_st.sclk_q = sclk;
    next_st.req.wr = 1'b0;
    next_st.load   = 1'b0;
    if (cs_n) begin
      next_st.cnt    = 5'd0;
      next_st.rd     = 1'b0;
      next_st.sdo_oe = 1'b0;
    end else begin
      if (rise) begin
        next_st.sh  = shifted;
        // Saturate so extra bits cannot wrap into a second frame
        if (st.cnt != `FML_FRAME_BITS) begin
          next_st.cnt = st.cnt + 5'd1;
        end
        if (st.cnt == 5'd0) begin
          next_st.rd = sdi;
        end
        // Address latched after 16 bits so read data is ready early
        if (st.cnt == `FML_ADDR_LAST_BIT) begin
          next_st.req.addr = shifted[14:0];
          next_st.load     = st.rd;
        end
        if (st.cnt == `FML_LAST_BIT && !st.rd) begin
          next_st.req.wr   = 1'b1;
          next_st.req.data = shifted[7:0];
        end
      end
      if (st.load) begin
        next_st.tx = rd_data;
      end
      if (fall && st.rd && st.cnt >= `FML_DATA_FIRST
          && st.cnt < `FML_FRAME_BITS) begin
        next_st.sdo    = st.tx[7];
        next_st.tx     = {st.tx[6:0], 1'b0};
        next_st.sdo_oe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sdo    = st.sdo;
  assign sdo_oe = st.sdo_oe;
  assign req    = st.req;

endmodule : fml_spi_slave

//--- verilog/fml_top.sv
// Fault status, mask, summary and per-lane buffer fault registers
`timescale 1ns/1ns
`include "fml_map.svh"
module fml_top
  import fml_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         soft_reset,
  // Serial register port
  input  wire logic         sclk,
  input  wire logic         cs_n,
  input  wire logic         sdi,
  output logic              sdo,
  output logic              sdo_oe,
  // Fault conditions from the converter
  input  wire logic [15:0]  lane_fault,
  input  wire logic [15:0]  lane_active,
  input  fml_fault_src_t    fault_src,
  // Summary outputs and cal status select
  input  wire logic         cal_status_sel,
  output logic              summary_flag,
  output logic              cal_status_pin
);

  fml_core_t    st;
  fml_core_t    next_st;
  fml_reg_req_t req;
  logic [7:0]   rd_data;
  logic [15:0]  lane_set;
  logic [15:0]  lane_clr;
  logic [5:0]   flag_set;
  logic         wr_status;
  logic         wr_mask;
  logic         wr_lo;
  logic         wr_hi;

  // ==========================================================
  // Address decode, shared by reads and writes
  function automatic logic hit(input logic [14:0] a,
                               input logic [14:0] target);
    hit = (a == target);
  endfunction : hit

  fml_spi_slave u_spi (
    .clk     (clk),
    .arst_n  (arst_n),
    .sclk    (sclk),
    .cs_n    (cs_n),
    .sdi     (sdi),
    .sdo     (sdo),
    .sdo_oe  (sdo_oe),
    .req     (req),
    .rd_data (rd_data)
  );

  assign wr_status = req.wr && hit(req.addr, `FML_ADDR_STATUS);
  assign wr_mask   = req.wr && hit(req.addr, `FML_ADDR_MASK);
  assign wr_lo     = req.wr && hit(req.addr, `FML_ADDR_LANES_LO);
  assign wr_hi     = req.wr && hit(req.addr, `FML_ADDR_LANES_HI);

  // ==========================================================
  // Event sources
  // Only lanes in use may raise a buffer fault
  assign lane_set = lane_fault & lane_active;
  assign flag_set = {|lane_set, fault_src};

  // Clear masks: a one clears, a zero keeps the bit
  always_comb begin
    lane_clr = 16'h0000;
    if (wr_lo) begin
      lane_clr[7:0] = req.data;
    end
    if (wr_hi) begin
      lane_clr[15:8] = req.data;
    end
    if (wr_status && req.data[`FML_BIT_LANE_BUF]) begin
      lane_clr = 16'hffff;
    end
  end

  // ==========================================================
  // Register update
  always_comb begin
    next_st = st;
    if (wr_mask) begin
      next_st.mask = req.data;
    end
    if (wr_status) begin
      next_st.status[7:6] = req.data[7:6];
      next_st.status[5:0] = st.status[5:0] & ~req.data[5:0];
    end
    // Set applied last so a same-cycle clear cannot lose an event
    next_st.status[5:0] = next_st.status[5:0] | flag_set;
    next_st.lanes = (st.lanes & ~lane_clr) | lane_set;
    if (soft_reset) begin
      next_st.mask   = `FML_MASK_RST;
      next_st.status = `FML_STATUS_RST;
      next_st.lanes  = `FML_LANES_RST;
    end
    // Summary follows the new flags so it never lags the status
    next_st.summary = |(next_st.status[5:0]
                        & ~next_st.mask[5:0]);
    next_st.cal_pin = cal_status_sel & next_st.summary;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st.mask    <= `FML_MASK_RST;
      st.status  <= `FML_STATUS_RST;
      st.lanes   <= `FML_LANES_RST;
      st.summary <= 1'b0;
      st.cal_pin <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_data = 8'h00;
    if (hit(req.addr, `FML_ADDR_SUMMARY)) begin
      rd_data = {7'h00, st.summary};
    end else if (hit(req.addr, `FML_ADDR_STATUS)) begin
      rd_data = st.status;
    end else if (hit(req.addr, `FML_ADDR_MASK)) begin
      rd_data = st.mask;
    end else if (hit(req.addr, `FML_ADDR_LANES_LO)) begin
      rd_data = st.lanes[7:0];
    end else if (hit(req.addr, `FML_ADDR_LANES_HI)) begin
      rd_data = st.lanes[15:8];
    end
  end

  assign summary_flag   = st.summary;
  assign cal_status_pin = st.cal_pin;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // Mask and summary
  a_mask_lane_lock: assert property (
    (st.mask[5] && st.mask[4]
     && !(|(st.status[3:0] & ~st.mask[3:0])))
    |-> !summary_flag)
    else $error("lane or lock fault leaked past its mask");

  a_mask_link_realign: assert property (
    (st.mask[3] && st.mask[2]
     && !(|({st.status[5:4], st.status[1:0]}
            & ~{st.mask[5:4], st.mask[1:0]})))
    |-> !summary_flag)
    else $error("link or realign fault leaked past its mask");

  a_mask_phase_div: assert property (
    (st.mask[1] && st.mask[0]
     && !(|(st.status[5:2] & ~st.mask[5:2])))
    |-> !summary_flag)
    else $error("phase or divider fault leaked past its mask");

  a_mask_soft_reset: assert property (
    soft_reset |=> (st.mask == `FML_MASK_RST))
    else $error("mask not restored by soft reset");

  a_mask_write: assert property (
    (wr_mask && !soft_reset) |=> (st.mask == $past(req.data)))
    else $error("mask write not stored");

  a_mask_hold: assert property (
    (!wr_mask && !soft_reset) |=> (st.mask == $past(st.mask)))
    else $error("mask changed without a write");

  a_summary_or: assert property (
    summary_flag == |(st.status[5:0] & ~st.mask[5:0]))
    else $error("summary disagrees with unmasked flags");

  a_summary_soft: assert property (
    soft_reset |=> !summary_flag)
    else $error("summary raised right after soft reset");

  a_cal_route: assert property (
    $past(cal_status_sel) |-> (cal_status_pin == summary_flag))
    else $error("cal status pin does not carry summary");

  a_cal_idle: assert property (
    !$past(cal_status_sel) |-> !cal_status_pin)
    else $error("cal status pin driven without select");

  a_cal_soft: assert property (
    soft_reset |=> !cal_status_pin)
    else $error("cal status pin raised right after soft reset");

  // ==========================================================
  // Status flags
  generate
    for (genvar i = 0; i < 6; i++) begin : g_flag_chk
      a_flag_set: assert property (
        flag_set[i] |=> st.status[i])
        else $error("status flag did not set on its event");

      a_flag_keep: assert property (
        (st.status[i] && !(wr_status && req.data[i]))
        |=> st.status[i])
        else $error("status flag lost without a clear");

      a_flag_clear: assert property (
        (wr_status && req.data[i] && !flag_set[i] && !soft_reset)
        |=> !st.status[i])
        else $error("status write of one did not clear flag");

      a_flag_unmasked: assert property (
        (st.status[i] && !st.mask[i]) |-> summary_flag)
        else $error("unmasked flag did not raise summary");
    end
  endgenerate

  a_status_soft_reset: assert property (
    soft_reset |=> (st.status[5:0] == 6'h3f))
    else $error("status flags not set by soft reset");

  a_status_clear: assert property (
    (wr_status && req.data[0] && !fault_src.divider
     && !soft_reset) |=> !st.status[0])
    else $error("status write of one did not clear");

  a_status_spare: assert property (
    (wr_status && !soft_reset)
    |=> (st.status[7:6] == $past(req.data[7:6])))
    else $error("spare status bits not stored");

  a_lane_status: assert property (
    (|(lane_fault & lane_active)) |=> st.status[5])
    else $error("active lane fault did not raise status");

  // ==========================================================
  // Per-lane flags
  generate
    for (genvar i = 0; i < 16; i++) begin : g_lane_chk
      a_lane_set: assert property (
        (lane_fault[i] && lane_active[i]) |=> st.lanes[i])
        else $error("lane fault bit did not set");

      a_lane_keep: assert property (
        (st.lanes[i] && !lane_clr[i]) |=> st.lanes[i])
        else $error("lane fault bit lost without a clear");

      a_lane_idle: assert property (
        (!st.lanes[i] && !(lane_fault[i] && lane_active[i])
         && !soft_reset) |=> !st.lanes[i])
        else $error("lane fault bit set with no event");
    end
  endgenerate

  a_lane_clear: assert property (
    (wr_lo && !soft_reset)
    |=> ((st.lanes[7:0] & $past(req.data)
          & ~$past(lane_set[7:0])) == 8'h00))
    else $error("write of ones did not clear lane bits");

  a_lane_clear_hi: assert property (
    (wr_hi && !soft_reset)
    |=> ((st.lanes[15:8] & $past(req.data)
          & ~$past(lane_set[15:8])) == 8'h00))
    else $error("write of ones did not clear upper lane bits");

  a_lane_clear_all: assert property (
    (wr_status && req.data[5] && !soft_reset)
    |=> ((st.lanes & ~$past(lane_set)) == 16'h0000))
    else $error("status clear did not empty lane register");

  a_lane_soft_reset: assert property (
    soft_reset |=> (st.lanes == `FML_LANES_RST))
    else $error("lane register not all ones after soft reset");

  // ==========================================================
  // Read data
  a_read_summary: assert property (
    hit(req.addr, `FML_ADDR_SUMMARY)
    |-> (rd_data == {7'h00, summary_flag}))
    else $error("summary read does not match flag");

  a_read_status: assert property (
    hit(req.addr, `FML_ADDR_STATUS) |-> (rd_data == st.status))
    else $error("status read does not match register");

  a_read_mask: assert property (
    hit(req.addr, `FML_ADDR_MASK) |-> (rd_data == st.mask))
    else $error("mask read does not match register");

  a_read_lanes: assert property (
    hit(req.addr, `FML_ADDR_LANES_LO)
    |-> (rd_data == st.lanes[7:0]))
    else $error("low lane read does not match register");

  a_read_lanes_hi: assert property (
    hit(req.addr, `FML_ADDR_LANES_HI)
    |-> (rd_data == st.lanes[15:8]))
    else $error("high lane read does not match register");

endmodule : fml_top

//--- verification/fml_tb.sv
// Register-level testbench for the fault mask and lane flag block
`timescale 1ns/1ns
`include "fml_map.svh"
module testbench
  import fml_pkg::*;
;
  // ==========================================================
  // Stimulus and observation
  logic           clk, arst_n, soft_reset, sclk, cs_n, sdi;
  logic           sdo, sdo_oe, summary_flag, cal_status_pin;
  logic           cal_status_sel;
  logic [15:0]    lane_fault, lane_active;
  fml_fault_src_t fault_src;
  int             err_total, comparisons, cycles;
  logic [7:0]     rd;
  logic           oe_seen;

  fml_top dut (
    .clk(clk), .arst_n(arst_n), .soft_reset(soft_reset),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .lane_fault(lane_fault), .lane_active(lane_active),
    .fault_src(fault_src), .cal_status_sel(cal_status_sel),
    .summary_flag(summary_flag), .cal_status_pin(cal_status_pin));

  always #10 clk = ~clk;

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("Mismatches %0d of %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Sizing: about 75 frames of roughly 175 cycles each
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  // ==========================================================
  // Serial frame: read flag, 15-bit address, 8-bit data, MSB first
  task automatic xfer(input logic rw, input logic [14:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {rw, a, d};
    q = 8'h00;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk) sdi <= f[i];
      // Sample sdo at the rising edge, long after the preceding fall
      @(posedge clk) begin
        if (i < 8) q[i] = sdo;
        if (i == 0) oe_seen = sdo_oe;
        sclk <= 1'b1;
      end
      repeat (3) @(posedge clk);
      sclk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    @(posedge clk) cs_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    xfer(1'b0, a, d, rd);
  endtask : wr

  task automatic rchk(input logic [14:0] a, input logic [7:0] exp);
    xfer(1'b1, a, 8'h00, rd);
    chk({8'h00, rd}, {8'h00, exp});
    chk(16'(oe_seen), 16'h0001);
    chk(16'(sdo_oe), 16'h0000);
  endtask : rchk

  // Hold fault conditions for a few cycles, then drop them
  task automatic fault(input logic [4:0] fs, input logic [15:0] lf,
                       input logic [15:0] la);
    @(posedge clk) begin
      fault_src   <= fml_fault_src_t'(fs);
      lane_fault  <= lf;
      lane_active <= la;
    end
    repeat (3) @(posedge clk);
    fault_src  <= '0;
    lane_fault <= 16'h0000;
    repeat (2) @(posedge clk);
  endtask : fault

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0; arst_n = 1'b0; soft_reset = 1'b0; sclk = 1'b0;
    cs_n = 1'b1; sdi = 1'b0; cal_status_sel = 1'b0;
    lane_fault = 16'h0000; lane_active = 16'hffff; fault_src = '0;
    err_total = 0; comparisons = 0; cycles = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(`FML_ADDR_MASK, 8'h3f);
    rchk(`FML_ADDR_STATUS, 8'h3f);
    rchk(`FML_ADDR_LANES_LO, 8'hff);
    rchk(`FML_ADDR_LANES_HI, 8'hff);
    rchk(`FML_ADDR_SUMMARY, 8'h00);
    rchk(15'h02c3, 8'h00);
    wr(`FML_ADDR_STATUS, 8'h3f);
    rchk(`FML_ADDR_STATUS, 8'h00);
    rchk(`FML_ADDR_LANES_LO, 8'h00);
    rchk(`FML_ADDR_LANES_HI, 8'h00);
    wr(`FML_ADDR_MASK, 8'hc0);
    rchk(`FML_ADDR_MASK, 8'hc0);
    chk(16'(summary_flag), 16'h0000);
    // Each flag in turn: raise, mask, unmask, clear
    for (int b = 0; b < 6; b++) begin
      if (b == 5) fault(5'h00, 16'h0001, 16'h0001);
      else fault(5'(1 << b), 16'h0000, 16'hffff);
      rchk(`FML_ADDR_STATUS, 8'(1 << b));
      chk(16'(summary_flag), 16'h0001);
      wr(`FML_ADDR_MASK, 8'(1 << b));
      chk(16'(summary_flag), 16'h0000);
      rchk(`FML_ADDR_SUMMARY, 8'h00);
      wr(`FML_ADDR_MASK, 8'h3f ^ 8'(1 << b));
      chk(16'(summary_flag), 16'h0001);
      rchk(`FML_ADDR_SUMMARY, 8'h01);
      @(posedge clk) cal_status_sel <= 1'b1;
      repeat (3) @(posedge clk);
      chk(16'(cal_status_pin), 16'h0001);
      cal_status_sel <= 1'b0;
      repeat (3) @(posedge clk);
      chk(16'(cal_status_pin), 16'h0000);
      wr(`FML_ADDR_STATUS, 8'(1 << b));
      chk(16'(summary_flag), 16'h0000);
      wr(`FML_ADDR_MASK, 8'h00);
    end
    rchk(`FML_ADDR_LANES_LO, 8'h00);
    // Inactive lanes are ignored; per-lane bits are write-one-clear
    fault(5'h00, 16'h8003, 16'hfffd);
    rchk(`FML_ADDR_LANES_LO, 8'h01);
    rchk(`FML_ADDR_LANES_HI, 8'h80);
    wr(`FML_ADDR_LANES_LO, 8'h00);
    rchk(`FML_ADDR_LANES_LO, 8'h01);
    wr(`FML_ADDR_LANES_LO, 8'h01);
    rchk(`FML_ADDR_LANES_LO, 8'h00);
    rchk(`FML_ADDR_LANES_HI, 8'h80);
    // Persisting lane fault wins over the clear
    @(posedge clk) lane_fault <= 16'h8000;
    wr(`FML_ADDR_LANES_HI, 8'h80);
    rchk(`FML_ADDR_LANES_HI, 8'h80);
    @(posedge clk) lane_fault <= 16'h0000;
    wr(`FML_ADDR_LANES_HI, 8'h80);
    rchk(`FML_ADDR_LANES_HI, 8'h00);
    // Soft reset restores every flag and the mask
    @(posedge clk) soft_reset <= 1'b1;
    @(posedge clk) soft_reset <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(`FML_ADDR_MASK, 8'h3f);
    rchk(`FML_ADDR_STATUS, 8'h3f);
    rchk(`FML_ADDR_LANES_HI, 8'hff);
    rchk(`FML_ADDR_LANES_LO, 8'hff);
    chk(16'(summary_flag), 16'h0000);
    wr(`FML_ADDR_STATUS, 8'hc0);
    rchk(`FML_ADDR_STATUS, 8'hff);
    give_verdict();
  end

endmodule : testbench
